/* File: focc_pkg.sv */
// Purpose: shared constants and types for the frequency offset compensation config block
// Assumes: 8-bit register file on a plain strobe port
// Notes: offsets are byte addresses of the register port
package focc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] CFG_OFFSET = 8'h19;
  localparam logic [7:0] STAT_OFFSET = 8'h40;
  localparam int GATE_BIT = 5;
  localparam int PRE_K_LSB = 3;
  localparam int POST_K_BIT = 2;
  localparam int LIMIT_LSB = 0;
  localparam logic [7:0] CFG_RESET = 8'h36;
  localparam logic [7:0] CFG_WMASK = 8'h3F;
  localparam int GAIN_W = 4;
  localparam int OFS_W = 16;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 4'h6;

  typedef struct packed {
    logic [1:0] rsvd;
    logic loop_freeze_until_sense;
    logic [1:0] pre_sync_freq_gain;
    logic post_sync_freq_gain;
    logic [1:0] freq_offset_saturation;
  } focc_cfg_t;

  // gain in units of K/2: 1 = K/2, 2 = K ... 8 = 4K
  typedef struct packed {
    logic loops_frozen;
    logic [GAIN_W-1:0] gain_half_k;
  } focc_loop_t;

  typedef enum logic [1:0] {
    FOCC_WAIT_SENSE = 2'b00,
    FOCC_PRE_SYNC = 2'b01,
    FOCC_POST_SYNC = 2'b11
  } focc_state_t;
endpackage

/* File: focc_clamp.sv */
// Purpose: clamp a signed frequency offset to a saturation setting
// Assumes: bandwidth input is unsigned, same width as offset
// Notes: registered output
`timescale 1ns/1ps
`default_nettype none
module focc_clamp #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // operands
  input wire logic [1:0] sat_code_i,
  input wire logic [W-1:0] chan_bw_i,
  input wire logic signed [W-1:0] ofs_i,
  // result
  output logic signed [W-1:0] ofs_o
);
  logic [W-1:0] lim;
  logic signed [W:0] pos_lim;
  logic signed [W:0] ofs_ext;
  logic signed [W-1:0] nxt_ofs;

  // limit select: bw/8, bw/4, bw/2
  always_comb
  begin
    case (sat_code_i)
      2'h1: lim = chan_bw_i >> 3;
      2'h2: lim = chan_bw_i >> 2;
      2'h3: lim = chan_bw_i >> 1;
      default: lim = '0;
    endcase
    pos_lim = $signed({1'b0, lim});
    ofs_ext = {ofs_i[W-1], ofs_i};
    if (sat_code_i == 2'h0)
      nxt_ofs = '0;
    else if (ofs_ext > pos_lim)
      nxt_ofs = pos_lim[W-1:0];
    else if (ofs_ext < -pos_lim)
      nxt_ofs = W'(-pos_lim);
    else
      nxt_ofs = ofs_i;
  end

  // registered clamp result
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ofs_o <= '0;
    else
      ofs_o <= nxt_ofs;
  end
endmodule
`default_nettype wire

/* File: focc_top.sv */
// How it works
// - gate bit freezes loops until sense
// - pre-sync gain K, 2K, 3K, 4K
// - post-sync gain same or K/2
// - clamp offset to 0, bw/8, /4, /2
//
// Purpose: frequency offset compensation configuration and loop control
// Assumes: sense, sync and offset inputs come from logic on clk_sys_i
// Notes: a packet ends with rx_restart_i, returning to the wait state
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module focc_top
  import focc_pkg::*;
#(
  parameter int OFS_WIDTH = focc_pkg::OFS_W
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [focc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [focc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [focc_pkg::DATA_W-1:0] reg_rdata_o,
  // demodulator events
  input wire logic carrier_sense_i,
  input wire logic sync_found_i,
  input wire logic rx_restart_i,
  // offset path
  input wire logic [OFS_WIDTH-1:0] chan_bw_i,
  input wire logic signed [OFS_WIDTH-1:0] raw_ofs_i,
  output logic signed [OFS_WIDTH-1:0] comp_ofs_o,
  // loop control
  output var focc_pkg::focc_loop_t loop_o
);
  import focc_pkg::*;

  focc_cfg_t cfg_ff;
  focc_state_t state_ff;
  focc_state_t nxt_state;
  focc_loop_t nxt_loop;
  logic [GAIN_W-1:0] pre_gain;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------

  // config write, reserved bits stay zero
  // reset value load
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cfg_ff <= focc_cfg_t'(CFG_RESET);
    else if (reg_wr_i && reg_addr_i == CFG_OFFSET)
      cfg_ff <= focc_cfg_t'(reg_wdata_i & CFG_WMASK);
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= '0;
    else if (reg_rd_i && reg_addr_i == CFG_OFFSET)
      reg_rdata_o <= cfg_ff;
    else if (reg_rd_i && reg_addr_i == STAT_OFFSET)
      reg_rdata_o <= {3'h0, loop_o.loops_frozen, 2'h0, state_ff};
    else
      reg_rdata_o <= '0;
  end

  // ------------------------------------------------------------
  // loop sequencing
  // ------------------------------------------------------------

  // wait for carrier sense when gated
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      FOCC_WAIT_SENSE:
        if (!cfg_ff.loop_freeze_until_sense || carrier_sense_i)
          nxt_state = FOCC_PRE_SYNC;
      FOCC_PRE_SYNC:
        if (sync_found_i)
          nxt_state = FOCC_POST_SYNC;
      FOCC_POST_SYNC:
        nxt_state = FOCC_POST_SYNC;
      default:
        nxt_state = FOCC_WAIT_SENSE;
    endcase
    if (rx_restart_i)
      nxt_state = FOCC_WAIT_SENSE;
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_ff <= FOCC_WAIT_SENSE;
    else
      state_ff <= nxt_state;
  end

  always_comb
  begin
    pre_gain = GAIN_W'({2'h0, cfg_ff.pre_sync_freq_gain} + 4'h1) << 1;
  end

  always_comb
  begin
    nxt_loop.loops_frozen = (nxt_state == FOCC_WAIT_SENSE) && cfg_ff.loop_freeze_until_sense;
    if (nxt_state == FOCC_POST_SYNC && cfg_ff.post_sync_freq_gain)
      nxt_loop.gain_half_k = 4'h1;
    else
      nxt_loop.gain_half_k = pre_gain;
  end

  // loop control register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      loop_o <= '{loops_frozen: 1'b1, gain_half_k: GAIN_RESET};
    else
      loop_o <= nxt_loop;
  end

  // ------------------------------------------------------------
  // offset saturation
  // ------------------------------------------------------------

  focc_clamp #(
    .W(OFS_WIDTH)
  ) u_clamp (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .sat_code_i(cfg_ff.freq_offset_saturation),
    .chan_bw_i(chan_bw_i),
    .ofs_i(raw_ofs_i),
    .ofs_o(comp_ofs_o)
  );

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------

  a_freeze_until_sense: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cfg_ff.loop_freeze_until_sense && !carrier_sense_i && state_ff == FOCC_WAIT_SENSE && !rx_restart_i)
    |=> loop_o.loops_frozen) else $error("loops not frozen before sense");

  a_release_on_sense: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (carrier_sense_i && !rx_restart_i) |=> !loop_o.loops_frozen) else $error("loops not released");

  a_pre_gain_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_ff == FOCC_PRE_SYNC && $stable(cfg_ff)) |=>
    (state_ff != FOCC_PRE_SYNC) || loop_o.gain_half_k == 2 * ({2'h0, $past(cfg_ff.pre_sync_freq_gain)} + 1))
    else $error("pre-sync gain wrong");

  a_post_half_k: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_ff == FOCC_POST_SYNC && cfg_ff.post_sync_freq_gain && !rx_restart_i)
    |=> loop_o.gain_half_k == 4'h1) else $error("post-sync gain not K/2");

  a_post_same_k: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_ff == FOCC_POST_SYNC && !cfg_ff.post_sync_freq_gain && !rx_restart_i)
    |=> loop_o.gain_half_k == $past(pre_gain)) else $error("post-sync gain not pre gain");

  a_zero_limit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cfg_ff.freq_offset_saturation == 2'h0) |=> comp_ofs_o == '0) else $error("offset not zeroed");

  a_half_bw_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cfg_ff.freq_offset_saturation == 2'h3) |=>
    ($signed({comp_ofs_o[OFS_WIDTH-1], comp_ofs_o}) <= $signed({2'b00, $past(chan_bw_i) >> 1})))
    else $error("offset above bw/2");

  a_rsvd_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == CFG_OFFSET) |=> reg_rdata_o[7:6] == 2'h0) else $error("reserved bits set");

  // ------------------------------------------------------------
  // loop and register checks
  // ------------------------------------------------------------

  a_gate_off_free: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (!cfg_ff.loop_freeze_until_sense && !rx_restart_i) |=> !loop_o.loops_frozen)
    else $error("loops frozen with gate off");

  a_restart_refreeze: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (rx_restart_i && cfg_ff.loop_freeze_until_sense) |=>
    (loop_o.loops_frozen && state_ff == FOCC_WAIT_SENSE)) else $error("restart did not refreeze");

  a_restart_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rx_restart_i |=> state_ff == FOCC_WAIT_SENSE) else $error("restart did not return to wait");

  a_wait_needs_sense: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_ff == FOCC_WAIT_SENSE && cfg_ff.loop_freeze_until_sense && !carrier_sense_i)
    |=> state_ff == FOCC_WAIT_SENSE) else $error("wait left without sense");

  a_frozen_in_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    loop_o.loops_frozen |-> state_ff == FOCC_WAIT_SENSE) else $error("frozen outside wait state");

  a_status_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == STAT_OFFSET) |=>
    (reg_rdata_o[4] == $past(loop_o.loops_frozen) && reg_rdata_o[1:0] == $past(state_ff)))
    else $error("status read wrong");

  // gain is K to 4K before sync
  a_pre_gain_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_ff != FOCC_POST_SYNC |-> loop_o.gain_half_k inside {4'h2, 4'h4, 4'h6, 4'h8})
    else $error("pre-sync gain outside K to 4K");

  a_sync_to_post: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_ff == FOCC_PRE_SYNC && sync_found_i && !rx_restart_i) |=> state_ff == FOCC_POST_SYNC)
    else $error("sync did not reach post-sync");

  a_pre_needs_sync: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_ff == FOCC_PRE_SYNC && !sync_found_i && !rx_restart_i) |=> state_ff == FOCC_PRE_SYNC)
    else $error("pre-sync left without sync");

  a_post_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_ff == FOCC_POST_SYNC && !rx_restart_i) |=> state_ff == FOCC_POST_SYNC)
    else $error("post-sync state left early");

  a_cfg_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == CFG_OFFSET) |=> cfg_ff == $past(reg_wdata_i & CFG_WMASK))
    else $error("config write lost");

  a_cfg_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !(reg_wr_i && reg_addr_i == CFG_OFFSET) |=> $stable(cfg_ff)) else $error("config changed unasked");

  a_cfg_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == CFG_OFFSET) |=> reg_rdata_o == $past(cfg_ff)) else $error("config read wrong");

  a_reset_value: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> (cfg_ff == CFG_RESET && loop_o.loops_frozen && loop_o.gain_half_k == GAIN_RESET))
    else $error("reset values wrong");

  // ------------------------------------------------------------
  // clamp check helpers
  // ------------------------------------------------------------

  logic [OFS_WIDTH:0] raw_mag;
  logic [OFS_WIDTH:0] comp_mag;
  logic [OFS_WIDTH:0] cur_lim;

  // magnitudes of raw and clamped offset, one bit wider
  always_comb
  begin
    if (raw_ofs_i[OFS_WIDTH-1])
      raw_mag = -{raw_ofs_i[OFS_WIDTH-1], raw_ofs_i};
    else
      raw_mag = {1'b0, raw_ofs_i};
    if (comp_ofs_o[OFS_WIDTH-1])
      comp_mag = -{comp_ofs_o[OFS_WIDTH-1], comp_ofs_o};
    else
      comp_mag = {1'b0, comp_ofs_o};
  end

  // limit due this cycle: zero, bw/8, bw/4, bw/2
  always_comb
  begin
    case (cfg_ff.freq_offset_saturation)
      2'h1: cur_lim = {1'b0, chan_bw_i >> 3};
      2'h2: cur_lim = {1'b0, chan_bw_i >> 2};
      2'h3: cur_lim = {1'b0, chan_bw_i >> 1};
      default: cur_lim = '0;
    endcase
  end

  // ------------------------------------------------------------
  // clamp checks
  // ------------------------------------------------------------

  a_clamp_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    1'b1 |=> comp_mag <= $past(cur_lim)) else $error("offset beyond saturation");

  a_clamp_pass: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (cfg_ff.freq_offset_saturation != 2'h0 && raw_mag <= cur_lim) |=> comp_ofs_o == $past(raw_ofs_i))
    else $error("offset inside limit altered");

  a_clamp_sat: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (raw_mag > cur_lim) |=> (comp_mag == $past(cur_lim)) &&
    (comp_ofs_o[OFS_WIDTH-1] == $past(raw_ofs_i[OFS_WIDTH-1]) || comp_mag == '0))
    else $error("offset not saturated to limit");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: self-checking bench for the offset compensation config block
// Assumes: model below tracks register, loop state and clamp per cycle
// Notes: random traffic on every input, mid-run reset included
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import focc_pkg::*;
  logic clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, carrier_sense_i, sync_found_i, rx_restart_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [15:0] chan_bw_i, raw_ofs_i, comp_ofs_o;
  focc_loop_t loop_o;
  int failures = 0;
  int n_tests = 0;
  int st, cfg, e_rd, e_frz, e_gain, e_ofs, lim, r, k;

  focc_top u_focc_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .carrier_sense_i(carrier_sense_i), .sync_found_i(sync_found_i), .rx_restart_i(rx_restart_i),
    .chan_bw_i(chan_bw_i), .raw_ofs_i(raw_ofs_i), .comp_ofs_o(comp_ofs_o), .loop_o(loop_o));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // clock at 100 ns period
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------
  // reference model, updated on the design's edge
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      st = 0;
      cfg = 'h36;
      e_rd = 0;
      e_frz = 1;
      e_gain = 6;
      e_ofs = 0;
    end
    else
    begin
      e_rd = !reg_rd_i ? 0 : reg_addr_i == CFG_OFFSET ? cfg :
        reg_addr_i == STAT_OFFSET ? (e_frz << 4 | st) : 0;
      if (rx_restart_i) st = 0;
      else if (st == 0 && (!cfg[5] || carrier_sense_i)) st = 1;
      else if (st == 1 && sync_found_i) st = 3;
      e_frz = (st == 0 && cfg[5]) ? 1 : 0;
      e_gain = (st == 3 && cfg[2]) ? 1 : (cfg[4:3] + 1) * 2;
      lim = cfg[1:0] == 0 ? 0 : int'(chan_bw_i) >> (4 - cfg[1:0]);
      r = int'($signed(raw_ofs_i));
      e_ofs = r > lim ? lim : r < -lim ? -lim : r;
      if (reg_wr_i && reg_addr_i == CFG_OFFSET) cfg = int'(reg_wdata_i & CFG_WMASK);
    end

  // compare every result mid-cycle
  always @(negedge clk_sys_i)
    if (rst_n_i)
    begin
      check(16'(reg_rdata_o), 16'(e_rd));
      check(16'(loop_o.loops_frozen), 16'(e_frz));
      check(16'(loop_o.gain_half_k), 16'(e_gain));
      check(comp_ofs_o, 16'(e_ofs));
    end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial
  begin
    {rst_n_i, reg_wr_i, reg_rd_i, carrier_sense_i, sync_found_i, rx_restart_i} = '0;
    reg_addr_i = CFG_OFFSET;
    reg_wdata_i = 8'h00;
    chan_bw_i = 16'h0000;
    raw_ofs_i = 16'h0000;
    void'($urandom(70234));
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge clk_sys_i);
      k = $urandom_range(3);
      reg_addr_i <= k == 0 ? CFG_OFFSET : k == 1 ? STAT_OFFSET : 8'($urandom);
      k = $urandom_range(3);
      reg_wr_i <= (k == 0);
      reg_rd_i <= (k >= 2);
      reg_wdata_i <= 8'($urandom);
      carrier_sense_i <= ($urandom_range(7) == 0);
      sync_found_i <= ($urandom_range(7) == 0);
      rx_restart_i <= ($urandom_range(15) == 0);
      chan_bw_i <= 16'($urandom);
      raw_ofs_i <= 16'($urandom);
      rst_n_i <= !(i >= 1500 && i < 1503);
    end
    conclude;
  end

  // watchdog beyond the expected run length
  initial
  begin
    #400000;
    failures++;
    conclude;
  end
endmodule
`default_nettype wire
